// *** verilog/aie_top.sv ***
// Converter event interrupt enable registers with status, mask and interrupt output
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module aie_top
  import aie_pkg::*;
#(
  parameter int unsigned NUM_EVENTS = AIE_NUM_EVENTS
) (
  input  wire logic                  clk,        // 125 MHz clock
  input  wire logic                  rst,        // Async reset, active high
  input  wire logic [AIE_ADDR_W-1:0] addr,       // Byte address
  input  wire logic [31:0]           wdata,      // Write data
  input  wire logic                  wr,         // Write strobe
  input  wire logic                  rd,         // Read strobe
  input  wire logic [NUM_EVENTS-1:0] event_in,   // Converter event pulses
  output logic      [31:0]           rdata,      // Read data, cycle after rd
  output logic      [NUM_EVENTS-1:0] enable_out, // Enable state per event
  output logic                       irq         // Level interrupt
);

  logic [NUM_EVENTS-1:0] enable;
  logic [NUM_EVENTS-1:0] status;
  logic [NUM_EVENTS-1:0] mask;
  logic [NUM_EVENTS-1:0] next_mask;
  logic [31:0]           next_rdata;
  logic [NUM_EVENTS-1:0] next_enable_out;
  logic                  next_irq;
  logic [NUM_EVENTS-1:0] set_vec;
  logic [NUM_EVENTS-1:0] clr_vec;
  logic [NUM_EVENTS-1:0] w1c_vec;
  logic [NUM_EVENTS-1:0] gated_event;
  aie_sel_t              wsel;

  // Shared decode for write paths
  function automatic aie_sel_t aie_decode(input logic [AIE_ADDR_W-1:0] a);
    if (a == AIE_OFS_SET) begin
      return AIE_SEL_SET;
    end else if (a == AIE_OFS_CLEAR) begin
      return AIE_SEL_CLEAR;
    end else if (a == AIE_OFS_STATUS || a == AIE_OFS_MASK) begin
      return AIE_SEL_OTHER;
    end
    return AIE_SEL_NONE;
  endfunction : aie_decode

  function automatic logic [31:0] aie_widen(input logic [NUM_EVENTS-1:0] v);
    logic [31:0] r;
    r = '0;
    r[NUM_EVENTS-1:0] = v;
    return r;
  endfunction : aie_widen

  always_comb begin
    wsel    = wr ? aie_decode(addr) : AIE_SEL_NONE;
    // Only ones act; zero bits leave enables alone
    set_vec = (wsel == AIE_SEL_SET) ? wdata[NUM_EVENTS-1:0] : '0;
    clr_vec = (wsel == AIE_SEL_CLEAR) ? wdata[NUM_EVENTS-1:0] : '0;
    w1c_vec = (wr && addr == AIE_OFS_STATUS) ? wdata[NUM_EVENTS-1:0] : '0;
  end

  // Each bit index maps one event: 0-5 core events, then channel limits high/low
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_evt
      aie_enable_bit u_en (
        .clk       (clk),
        .rst       (rst),
        .set_pulse (set_vec[gi]),
        .clr_pulse (clr_vec[gi]),
        .enable    (enable[gi])
      );
      // Disabled events never reach the status register
      assign gated_event[gi] = event_in[gi] & enable[gi];
      aie_status_bit u_st (
        .clk      (clk),
        .rst      (rst),
        .event_in (gated_event[gi]),
        .w1c      (w1c_vec[gi]),
        .flag     (status[gi])
      );
    end
  endgenerate

  always_comb begin
    next_mask = mask;
    if (wr && addr == AIE_OFS_MASK) begin
      next_mask = wdata[NUM_EVENTS-1:0];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        AIE_OFS_SET:    next_rdata = aie_widen(enable);
        AIE_OFS_CLEAR:  next_rdata = aie_widen(enable);
        AIE_OFS_STATUS: next_rdata = aie_widen(status);
        AIE_OFS_MASK:   next_rdata = aie_widen(mask);
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
    next_enable_out = enable;
    next_irq        = |(status & mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask       <= AIE_RST_MASK[NUM_EVENTS-1:0];
      rdata      <= 32'h0000_0000;
      enable_out <= AIE_RST_ENABLE[NUM_EVENTS-1:0];
      irq        <= 1'b0;
    end else begin
      mask       <= next_mask;
      rdata      <= next_rdata;
      enable_out <= next_enable_out;
      irq        <= next_irq;
    end
  end

  // Assertions
  a_set_enables: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[0]) |=> enable[0])
    else $error("enable bit 0 not set by write one");
  a_zero_keeps: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[NUM_EVENTS-1:0] == '0)
      |=> enable == $past(enable))
    else $error("zero write to set register changed enables");
  a_clear_disables: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_CLEAR && wdata[12]) |=> !enable[12])
    else $error("clear write did not disable bit 12");
  a_read_back: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == AIE_OFS_SET) |=> rdata[NUM_EVENTS-1:0] == $past(enable))
    else $error("set register read does not show enables");
  a_read_upper_zero: assert property (@(posedge clk) disable iff (rst)
    rd |=> rdata[31:NUM_EVENTS] == '0)
    else $error("unused read bits not zero");
  a_high_bit_set: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[21]) |=> enable[21] ##1 enable_out[21])
    else $error("bit 21 enable not set and shown");
  a_chan0_set: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[7:6] == 2'b11) |=> enable[7:6] == 2'b11)
    else $error("channel 0 limit enables not set");
  a_chan12_set: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[11:8] == 4'hf) |=> enable[11:8] == 4'hf)
    else $error("channel 1 and 2 enables not set");
  a_core_set: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[5:0] == 6'h3f) |=> enable[5:0] == 6'h3f)
    else $error("core event enables not set");
  a_bit12_hold: assert property (@(posedge clk) disable iff (rst)
    (enable[12] && !(wr && addr == AIE_OFS_CLEAR && wdata[12])) |=> enable[12])
    else $error("bit 12 dropped without clear");
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    |(status & mask) |=> irq)
    else $error("interrupt not raised");

  // Set register: every field group and the all-ones write
  a_set_end: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[1])
    |=> enable[1])
    else $error("end enable not set");

  a_set_stopped: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[5])
    |=> enable[5])
    else $error("stopped enable not set");

  a_set_chan0_low: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[7])
    |=> enable[7])
    else $error("channel 0 lower enable not set");

  a_set_chan1_low: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[9])
    |=> enable[9])
    else $error("channel 1 lower enable not set");

  a_set_chan2_low: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[11])
    |=> enable[11])
    else $error("channel 2 lower enable not set");

  a_set_bit12: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[12])
    |=> enable[12])
    else $error("channel 3 upper enable not set");

  a_set_chan3_low: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[13])
    |=> enable[13])
    else $error("channel 3 lower enable not set");

  a_set_chan4_6: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[19:14] == 6'h3f)
    |=> enable[19:14] == 6'h3f)
    else $error("channel 4 to 6 enables not set");

  a_set_chan7: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[21:20] == 2'b11)
    |=> enable[21:20] == 2'b11)
    else $error("channel 7 enables not set");

  a_set_all_ones: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET && wdata[NUM_EVENTS-1:0] == '1)
    |=> enable == '1)
    else $error("all-ones set write left an enable low");

  // A set write may only add enables, never drop one
  a_set_only_adds: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET)
    |=> (enable & $past(enable)) == $past(enable))
    else $error("set write dropped an enable");

  a_set_exact: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_SET)
    |=> enable == ($past(enable) | $past(wdata[NUM_EVENTS-1:0])))
    else $error("set write result wrong");

  // Clear register shares the enable state with the set register
  a_clear_exact: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_CLEAR)
    |=> enable == ($past(enable) & ~$past(wdata[NUM_EVENTS-1:0])))
    else $error("clear write result wrong");

  a_clear_bit0: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_CLEAR && wdata[0])
    |=> !enable[0])
    else $error("clear write did not disable bit 0");

  a_clear_bit21: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_CLEAR && wdata[21])
    |=> !enable[21])
    else $error("clear write did not disable bit 21");

  a_clear_core: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_CLEAR && wdata[5:0] == 6'h3f)
    |=> enable[5:0] == 6'h00)
    else $error("core event enables not cleared");

  a_clear_chan0: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_CLEAR && wdata[7:6] == 2'b11)
    |=> enable[7:6] == 2'b00)
    else $error("channel 0 enables not cleared");

  a_clear_only_drops: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_CLEAR)
    |=> (enable & ~$past(enable)) == '0)
    else $error("clear write raised an enable");

  // Enables move only on a set or clear write; events never touch them
  a_enable_quiet: assert property (@(posedge clk) disable iff (rst)
    !(wr && (addr == AIE_OFS_SET || addr == AIE_OFS_CLEAR))
    |=> enable == $past(enable))
    else $error("enable changed without a write");

  // Read path: data stands one cycle after the strobe, zero otherwise
  a_read_clear_reg: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == AIE_OFS_CLEAR)
    |=> rdata[NUM_EVENTS-1:0] == $past(enable))
    else $error("clear register read does not show enables");

  a_read_bit12: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == AIE_OFS_SET && enable[12])
    |=> rdata[12])
    else $error("bit 12 enable not read back");

  a_read_status: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == AIE_OFS_STATUS)
    |=> rdata[NUM_EVENTS-1:0] == $past(status))
    else $error("status read wrong");

  a_read_mask: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == AIE_OFS_MASK)
    |=> rdata[NUM_EVENTS-1:0] == $past(mask))
    else $error("mask read wrong");

  a_read_unmapped: assert property (@(posedge clk) disable iff (rst)
    (rd && aie_decode(addr) == AIE_SEL_NONE)
    |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !rd
    |=> rdata == 32'h0000_0000)
    else $error("read data stands without a read");

  a_enable_out_copy: assert property (@(posedge clk) disable iff (rst)
    1'b1
    |=> enable_out == $past(enable))
    else $error("enable output does not follow enables");

  // Status, mask and interrupt; set wins over a same-cycle clear
  a_status_set: assert property (@(posedge clk) disable iff (rst)
    gated_event[0]
    |=> status[0])
    else $error("enabled event did not set status");

  a_status_top: assert property (@(posedge clk) disable iff (rst)
    gated_event[NUM_EVENTS-1]
    |=> status[NUM_EVENTS-1])
    else $error("enabled top event did not set status");

  a_status_gated: assert property (@(posedge clk) disable iff (rst)
    (!enable[0] && !status[0])
    |=> !status[0])
    else $error("disabled event reached status");

  a_status_sticky: assert property (@(posedge clk) disable iff (rst)
    (status[0] && !w1c_vec[0])
    |=> status[0])
    else $error("status dropped without a clear");

  a_status_w1c: assert property (@(posedge clk) disable iff (rst)
    (w1c_vec[0] && !gated_event[0])
    |=> !status[0])
    else $error("status not cleared by write one");

  a_status_set_wins: assert property (@(posedge clk) disable iff (rst)
    (w1c_vec[0] && gated_event[0])
    |=> status[0])
    else $error("clear beat a same-cycle event");

  a_mask_write: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == AIE_OFS_MASK)
    |=> mask == $past(wdata[NUM_EVENTS-1:0]))
    else $error("mask write not taken");

  a_mask_hold: assert property (@(posedge clk) disable iff (rst)
    !(wr && addr == AIE_OFS_MASK)
    |=> mask == $past(mask))
    else $error("mask changed without a write");

  a_irq_low: assert property (@(posedge clk) disable iff (rst)
    ((status & mask) == '0)
    |=> !irq)
    else $error("interrupt raised with nothing pending");

endmodule : aie_top

// *** verilog/aie_pkg.sv ***
// Package: offsets, field positions, reset values and event indices for the enable block
package aie_pkg;
  localparam int unsigned AIE_NUM_EVENTS = 22;
  localparam int unsigned AIE_ADDR_W     = 12;

  localparam logic [11:0] AIE_OFS_STATUS = 12'h0_100;
  localparam logic [11:0] AIE_OFS_MASK   = 12'h0_104;
  localparam logic [11:0] AIE_OFS_SET    = 12'h0_304;
  localparam logic [11:0] AIE_OFS_CLEAR  = 12'h0_308;

  localparam logic [31:0] AIE_RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] AIE_RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] AIE_RST_MASK   = 32'h0000_0000;

  localparam int unsigned AIE_BIT_STARTED      = 0;
  localparam int unsigned AIE_BIT_END          = 1;
  localparam int unsigned AIE_BIT_DONE         = 2;
  localparam int unsigned AIE_BIT_RESULT_DONE  = 3;
  localparam int unsigned AIE_BIT_CAL_DONE     = 4;
  localparam int unsigned AIE_BIT_STOPPED      = 5;
  localparam int unsigned AIE_BIT_CHAN0_UPPER  = 6;
  localparam int unsigned AIE_BIT_CHAN_STRIDE  = 2;

  typedef enum logic [3:0] {
    AIE_SEL_NONE   = 4'b0001,
    AIE_SEL_SET    = 4'b0010,
    AIE_SEL_CLEAR  = 4'b0100,
    AIE_SEL_OTHER  = 4'b1000
  } aie_sel_t;
endpackage : aie_pkg

// *** verilog/aie_enable_bit.sv ***
// One enable bit with write-one-to-set and write-one-to-clear
`timescale 1ns/1ps
module aie_enable_bit (
  input  wire logic clk,       // Clock
  input  wire logic rst,       // Async reset
  input  wire logic set_pulse, // Write one to set register
  input  wire logic clr_pulse, // Write one to clear register
  output logic      enable     // Present enable state
);
  logic next_enable;

  always_comb begin
    next_enable = enable;
    if (clr_pulse) begin
      next_enable = 1'b0;
    end
    if (set_pulse) begin
      next_enable = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable <= 1'b0;
    end else begin
      enable <= next_enable;
    end
  end
endmodule : aie_enable_bit

// *** verilog/aie_status_bit.sv ***
// One sticky event flag, cleared by writing a one; set wins over clear
`timescale 1ns/1ps
module aie_status_bit (
  input  wire logic clk,     // Clock
  input  wire logic rst,     // Async reset
  input  wire logic event_in, // Event pulse
  input  wire logic w1c,     // Clear request
  output logic      flag     // Sticky flag
);
  logic next_flag;

  always_comb begin
    next_flag = flag;
    if (w1c) begin
      next_flag = 1'b0;
    end
    if (event_in) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule : aie_status_bit

// *** tb/aie_top_test.sv ***
// Self-checking testbench for the converter event interrupt enable block
`timescale 1ns/1ps
module aie_top_test;
  import aie_pkg::*;
  logic        clk;
  logic        rst;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [21:0] event_in;
  logic [31:0] rdata;
  logic [21:0] enable_out;
  logic        irq;
  logic [31:0] exp_q[$];
  logic [31:0] exp_en;
  logic [31:0] rnd;
  logic [31:0] clr;
  logic        rd_seen;
  int          n_mismatch;
  int          samples_checked;

  aie_top i_aie_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .event_in(event_in), .rdata(rdata), .enable_out(enable_out), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // Expected data is queued when the read is issued, compared by the watcher
  task automatic reg_rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : reg_rd

  // Read data stands only in the cycle after the strobe, so sample exactly there
  always @(posedge clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      check("rdata", rdata, exp_q.pop_front());
    end
    rd_seen <= rd;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rst = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    event_in = '0;
    rd_seen = 1'b0;
    exp_en = AIE_RST_ENABLE;
    n_mismatch = 0;
    samples_checked = 0;
    void'($urandom(79));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    reg_rd(AIE_OFS_SET, AIE_RST_ENABLE);
    // Walking one; each set is followed by an all-zero write that must change nothing
    for (int i = 0; i < 22; i++) begin
      exp_en[i] = 1'b1;
      reg_wr(AIE_OFS_SET, 32'h0000_0001 << i);
      reg_wr(AIE_OFS_SET, 32'h0000_0000);
      reg_rd(AIE_OFS_SET, exp_en);
      // Registered outputs are looked at away from the edge that launches them
      @(negedge clk);
      check("enable_out", {10'h000, enable_out}, exp_en);
    end
    // Random set and clear words; upper unused bits are driven too
    for (int k = 0; k < 6; k++) begin
      rnd = $urandom();
      clr = $urandom();
      reg_wr(AIE_OFS_SET, rnd);
      exp_en = (exp_en | rnd) & 32'h003F_FFFF;
      reg_rd(AIE_OFS_SET, exp_en);
      reg_wr(AIE_OFS_CLEAR, clr);
      exp_en = exp_en & ~clr;
      reg_rd(AIE_OFS_SET, exp_en);
      reg_rd(AIE_OFS_CLEAR, exp_en);
    end
    reg_wr(12'h0_300, 32'hFFFF_FFFF);
    reg_rd(12'h0_200, 32'h0000_0000);
    reg_rd(AIE_OFS_SET, exp_en);
    // Interrupt path: only an enabled event reaches status
    reg_wr(AIE_OFS_CLEAR, 32'hFFFF_FFFF);
    reg_wr(AIE_OFS_SET, 32'h0000_0008);
    reg_wr(AIE_OFS_MASK, 32'h0000_0008);
    @(posedge clk);
    event_in <= 22'h00_000A;
    @(posedge clk);
    event_in <= '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("irq", {31'h0, irq}, 32'h0000_0001);
    reg_rd(AIE_OFS_STATUS, 32'h0000_0008);
    reg_wr(AIE_OFS_MASK, 32'h0000_0000);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    reg_wr(AIE_OFS_MASK, 32'h0000_0008);
    reg_wr(AIE_OFS_STATUS, 32'h0000_0008);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    reg_rd(AIE_OFS_STATUS, 32'h0000_0000);
    // Second reset in mid-run must drop every enable
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reg_rd(AIE_OFS_SET, AIE_RST_ENABLE);
    for (int k = 0; k < 10 && exp_q.size() > 0; k++) begin
      @(posedge clk);
    end
    if (exp_q.size() != 0) begin
      n_mismatch++;
    end
    tally_and_finish();
  end
endmodule : aie_top_test
